// ==== hdl/bram_pkg.sv ====
// Shared constants, register map and width helpers for the embedded block RAM.
package bram_pkg;

  // Array geometry: 2048 entries of one byte plus its parity bit.
  localparam int ENTRY_BITS = 9;
  localparam int BYTE_BITS = 8;
  localparam int ENTRIES = 2048;
  localparam int MEM_BITS = ENTRIES * ENTRY_BITS;
  localparam int ENTRY_AW = 11;
  localparam int ADDR_W = 14;
  localparam int DATA_W = 36;
  localparam int BE_W = 4;

  // Port width codes.
  localparam logic [2:0] W_X1 = 3'h0;
  localparam logic [2:0] W_X2 = 3'h1;
  localparam logic [2:0] W_X4 = 3'h2;
  localparam logic [2:0] W_X9 = 3'h3;
  localparam logic [2:0] W_X18 = 3'h4;
  localparam logic [2:0] W_X36 = 3'h5;

  // Write behaviour codes.
  localparam logic [1:0] WM_NORMAL = 2'h0;
  localparam logic [1:0] WM_THRU = 2'h1;
  localparam logic [1:0] WM_RBW = 2'h2;

  // Memory organisation codes.
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_TRUE = 2'h1;
  localparam logic [1:0] MODE_PSEUDO = 2'h2;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFG_A = 8'h04;
  localparam logic [7:0] OFS_CFG_B = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_INIT_ADDR = 8'h10;
  localparam logic [7:0] OFS_INIT_DATA = 8'h14;

  // Field positions.
  localparam int CTRL_RUN = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CFG_WIDTH_LSB = 0;
  localparam int CFG_WMODE_LSB = 3;
  localparam int CFG_OUTREG = 5;
  localparam int CFG_RSTSYNC = 6;
  localparam int CFG_BITS = 7;
  localparam int STAT_ERR = 0;
  localparam int STAT_ACTIVE = 1;

  // Reset values.
  localparam logic [6:0] CFG_RST = 7'h03;
  localparam logic [1:0] MODE_RST = 2'h0;

  // Number of data bits a port of the given width carries.
  function automatic int width_bits(input logic [2:0] w);
    case (w)
      W_X1: return 1;
      W_X2: return 2;
      W_X4: return 4;
      W_X9: return 9;
      W_X18: return 18;
      W_X36: return 36;
      default: return 0;
    endcase
  endfunction : width_bits

  // Address bits that are meaningful at the given width.
  function automatic logic [13:0] depth_mask(input logic [2:0] w);
    if (w < W_X9) return 14'h3FFF >> w;
    if (w <= W_X36) return 14'h07FF >> (w - W_X9);
    return 14'h0000;
  endfunction : depth_mask

endpackage : bram_pkg

// ==== hdl/bram_port.sv ====
// One memory port: input capture, output latch, optional output register and resets.
`timescale 1ns/1ns
`default_nettype none
module bram_port #(
  parameter int DATA_W = bram_pkg::DATA_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic we,
  input wire logic [bram_pkg::BE_W-1:0] be,
  input wire logic [bram_pkg::ADDR_W-1:0] addr,
  input wire logic [bram_pkg::DATA_W-1:0] wdata,
  input wire logic out_rst,
  input wire logic glob_clr,
  input wire logic [2:0] width,
  input wire logic [1:0] wmode,
  input wire logic outreg,
  input wire logic rst_sync,
  input wire logic [bram_pkg::DATA_W-1:0] rd_word,
  output logic act_q,
  output logic we_q,
  output logic [bram_pkg::BE_W-1:0] be_q,
  output logic [bram_pkg::ADDR_W-1:0] addr_q,
  output logic [bram_pkg::DATA_W-1:0] wdata_q,
  output logic [bram_pkg::DATA_W-1:0] dout
);

  if (DATA_W != bram_pkg::DATA_W) begin : g_check
    $error("bram_port supports only the full 36-bit data path");
  end

  typedef struct packed {
    logic act;
    logic we;
    logic [bram_pkg::BE_W-1:0] be;
    logic [bram_pkg::ADDR_W-1:0] addr;
    logic [bram_pkg::DATA_W-1:0] wdata;
    logic [bram_pkg::DATA_W-1:0] latch;
    logic [bram_pkg::DATA_W-1:0] oreg;
    logic [bram_pkg::DATA_W-1:0] dout;
  } port_state_type;

  port_state_type st_ff;
  port_state_type nxt_st;

  always_comb begin
    logic [bram_pkg::DATA_W-1:0] mask;
    mask = '0;
    for (int k = 0; k < bram_pkg::DATA_W; k++) begin
      if (k < bram_pkg::width_bits(width)) mask[k] = 1'b1;
    end
    nxt_st = st_ff;
    // A disabled edge captures nothing and starts no array cycle.
    nxt_st.act = ce; // see RQ19
    if (ce) begin
      nxt_st.we = we; // see RQ10
      nxt_st.be = be; // see RQ10
      nxt_st.addr = addr; // see RQ10
      nxt_st.wdata = wdata & mask; // see RQ10
    end
    if (st_ff.act) begin
      if (!st_ff.we) begin
        nxt_st.latch = rd_word;
      end else begin
        case (wmode)
          bram_pkg::WM_THRU: nxt_st.latch = st_ff.wdata; // see RQ13
          bram_pkg::WM_RBW: nxt_st.latch = rd_word; // see RQ14
          default: nxt_st.latch = st_ff.latch; // see RQ12
        endcase
      end
    end
    if (ce) nxt_st.oreg = st_ff.latch; // see RQ11
    // Asynchronous mode clears regardless of the enable; synchronous waits for it.
    if (glob_clr || (out_rst && (!rst_sync || ce))) begin // see RQ15
      nxt_st.latch = '0; // see RQ18
      nxt_st.oreg = '0; // see RQ18
    end
    nxt_st.dout = outreg ? nxt_st.oreg : nxt_st.latch; // see RQ11
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign act_q = st_ff.act;
  assign we_q = st_ff.we;
  assign be_q = st_ff.be;
  assign addr_q = st_ff.addr;
  assign wdata_q = st_ff.wdata;
  assign dout = st_ff.dout;

endmodule : bram_port
`default_nettype wire

// ==== hdl/embedded_block_ram.sv ====
// Embedded 18 Kb block RAM with two ports and an AHB-Lite setup interface.
//
// Summary of operation
// RQ1 - 18 Kb array with registered inputs, outputs, per-port clock enable.
// RQ2 - Single port widths 16384x1 up to 512x36.
// RQ3 - Single, true dual and pseudo dual port; x36 not in true dual.
// RQ4 - Each byte carries a ninth parity bit stored for user checking.
// RQ5 - Byte write enables act only at 18 and 36 bit widths.
// RQ6 - Each port chooses its own width in multi-port modes.
// RQ7 - Words map into storage LSB first, word 0 lowest, at every width.
// RQ8 - Contents can be preloaded before user operation starts.
// RQ9 - For ROM use the fabric keeps write enables low.
// RQ10 - Address and write data are registered before the array.
// RQ11 - Read data optionally passes an output register.
// RQ12 - Normal mode: output holds during writes, updates on reads.
// RQ13 - Write-through mode: written data appears on the same port.
// RQ14 - Read-before-write: old word appears; only at 9, 18, 36 bits.
// RQ15 - Output latch reset is selectable asynchronous or synchronous.
// RQ16 - Each port's local reset clears only its own outputs.
// RQ17 - Active low global reset clears both ports' outputs.
// RQ18 - Resets zero outputs and never touch stored contents.
// RQ19 - With clock enable low a port holds and performs no access.
`timescale 1ns/1ns
`default_nettype none
module embedded_block_ram (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA,
  input wire logic GLOBAL_RESET_N,
  input wire logic PORT_A_CE,
  input wire logic PORT_A_WE,
  input wire logic [bram_pkg::BE_W-1:0] PORT_A_BE,
  input wire logic [bram_pkg::ADDR_W-1:0] PORT_A_ADDR,
  input wire logic [bram_pkg::DATA_W-1:0] PORT_A_WDATA,
  input wire logic PORT_A_OUTPUT_RESET,
  output logic [bram_pkg::DATA_W-1:0] PORT_A_RDATA,
  input wire logic PORT_B_CE,
  input wire logic PORT_B_WE,
  input wire logic [bram_pkg::BE_W-1:0] PORT_B_BE,
  input wire logic [bram_pkg::ADDR_W-1:0] PORT_B_ADDR,
  input wire logic [bram_pkg::DATA_W-1:0] PORT_B_WDATA,
  input wire logic PORT_B_OUTPUT_RESET,
  output logic [bram_pkg::DATA_W-1:0] PORT_B_RDATA
);

  typedef struct packed {
    logic run;
    logic [1:0] mode;
    logic [bram_pkg::CFG_BITS-1:0] cfg_a;
    logic [bram_pkg::CFG_BITS-1:0] cfg_b;
    logic [bram_pkg::ENTRY_AW-1:0] init_addr;
    logic gsync1;
    logic gsync2;
    logic wpend;
    logic [7:0] waddr;
    logic hready;
    logic hresp;
    logic [31:0] hrdata;
  } core_state_type;

  core_state_type st_ff;
  core_state_type nxt_st;

  // Storage has no reset so that resets leave the contents alone.
  logic [bram_pkg::MEM_BITS-1:0] mem_ff;
  logic [bram_pkg::MEM_BITS-1:0] nxt_mem;

  logic a_act;
  logic a_we;
  logic [bram_pkg::BE_W-1:0] a_be;
  logic [bram_pkg::ADDR_W-1:0] a_addr;
  logic [bram_pkg::DATA_W-1:0] a_wdata;
  logic [bram_pkg::DATA_W-1:0] a_rd;
  logic [bram_pkg::DATA_W-1:0] a_dout;
  logic b_act;
  logic b_we;
  logic [bram_pkg::BE_W-1:0] b_be;
  logic [bram_pkg::ADDR_W-1:0] b_addr;
  logic [bram_pkg::DATA_W-1:0] b_wdata;
  logic [bram_pkg::DATA_W-1:0] b_rd;
  logic [bram_pkg::DATA_W-1:0] b_dout;
  logic cfg_err;
  logic active;
  logic a_ce;
  logic b_ce;
  logic a_we_in;
  logic b_we_in;
  logic glob_clr;
  logic init_we;
  logic bus_sel;

  // Bit position in storage of data bit k of the word at address a.
  function automatic int flat_idx(input logic [13:0] a, input logic [2:0] w, input int k);
    int lin;
    lin = int'(a & bram_pkg::depth_mask(w)) * bram_pkg::width_bits(w) + k;
    // Narrow widths use only the eight data bits of each entry.
    if (w < bram_pkg::W_X9) begin // see RQ7
      return (lin / bram_pkg::BYTE_BITS) * bram_pkg::ENTRY_BITS + lin % bram_pkg::BYTE_BITS;
    end
    return lin; // see RQ7
  endfunction : flat_idx

  function automatic logic [35:0] rd_word(
    input logic [bram_pkg::MEM_BITS-1:0] m,
    input logic [13:0] a,
    input logic [2:0] w
  );
    logic [35:0] r;
    r = '0;
    for (int k = 0; k < bram_pkg::DATA_W; k++) begin
      if (k < bram_pkg::width_bits(w)) r[k] = m[flat_idx(a, w, k)];
    end
    return r;
  endfunction : rd_word

  function automatic logic [bram_pkg::MEM_BITS-1:0] wr_word(
    input logic [bram_pkg::MEM_BITS-1:0] m,
    input logic [13:0] a,
    input logic [2:0] w,
    input logic [3:0] be,
    input logic [35:0] d
  );
    logic [bram_pkg::MEM_BITS-1:0] r;
    r = m;
    for (int k = 0; k < bram_pkg::DATA_W; k++) begin
      // Byte lanes gate the write only at the two widest widths.
      if (k < bram_pkg::width_bits(w) &&
          (w < bram_pkg::W_X18 || be[k / bram_pkg::ENTRY_BITS])) begin // see RQ5
        r[flat_idx(a, w, k)] = d[k]; // see RQ4
      end
    end
    return r;
  endfunction : wr_word

  // Rejects combinations the array cannot serve.
  function automatic logic cfg_bad(
    input logic [1:0] mode,
    input logic [bram_pkg::CFG_BITS-1:0] ca,
    input logic [bram_pkg::CFG_BITS-1:0] cb
  );
    logic [2:0] wa;
    logic [2:0] wb;
    logic [1:0] ma;
    logic [1:0] mb;
    wa = ca[bram_pkg::CFG_WIDTH_LSB +: 3];
    wb = cb[bram_pkg::CFG_WIDTH_LSB +: 3];
    ma = ca[bram_pkg::CFG_WMODE_LSB +: 2];
    mb = cb[bram_pkg::CFG_WMODE_LSB +: 2];
    if (mode != bram_pkg::MODE_SINGLE && mode != bram_pkg::MODE_TRUE &&
        mode != bram_pkg::MODE_PSEUDO) return 1'b1; // see RQ3
    if (wa > bram_pkg::W_X36 || wb > bram_pkg::W_X36) return 1'b1; // see RQ2
    if (mode == bram_pkg::MODE_TRUE &&
        (wa == bram_pkg::W_X36 || wb == bram_pkg::W_X36)) return 1'b1; // see RQ3
    if (ma > bram_pkg::WM_RBW || mb > bram_pkg::WM_RBW) return 1'b1;
    if (ma == bram_pkg::WM_RBW && wa < bram_pkg::W_X9) return 1'b1; // see RQ14
    if (mb == bram_pkg::WM_RBW && wb < bram_pkg::W_X9) return 1'b1; // see RQ14
    return 1'b0;
  endfunction : cfg_bad

  assign cfg_err = cfg_bad(st_ff.mode, st_ff.cfg_a, st_ff.cfg_b);
  // User access opens only after setup and preloading are finished.
  assign active = st_ff.run && !cfg_err; // see RQ8
  assign a_ce = PORT_A_CE && active; // see RQ19
  assign b_ce = PORT_B_CE && active && st_ff.mode != bram_pkg::MODE_SINGLE; // see RQ3
  assign a_we_in = PORT_A_WE;
  // In pseudo dual port mode port B is the read side.
  assign b_we_in = PORT_B_WE && st_ff.mode != bram_pkg::MODE_PSEUDO; // see RQ3
  assign glob_clr = !st_ff.gsync2; // see RQ17
  assign bus_sel = HSEL && HTRANS[1] && HREADY;
  assign init_we = st_ff.wpend && st_ff.waddr == bram_pkg::OFS_INIT_DATA && !st_ff.run; // see RQ8

  assign a_rd = rd_word(mem_ff, a_addr, st_ff.cfg_a[bram_pkg::CFG_WIDTH_LSB +: 3]); // see RQ6
  assign b_rd = rd_word(mem_ff, b_addr, st_ff.cfg_b[bram_pkg::CFG_WIDTH_LSB +: 3]); // see RQ6

  bram_port u_port_a (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .ce(a_ce),
    .we(a_we_in),
    .be(PORT_A_BE),
    .addr(PORT_A_ADDR),
    .wdata(PORT_A_WDATA),
    .out_rst(PORT_A_OUTPUT_RESET), // see RQ16
    .glob_clr(glob_clr),
    .width(st_ff.cfg_a[bram_pkg::CFG_WIDTH_LSB +: 3]),
    .wmode(st_ff.cfg_a[bram_pkg::CFG_WMODE_LSB +: 2]),
    .outreg(st_ff.cfg_a[bram_pkg::CFG_OUTREG]),
    .rst_sync(st_ff.cfg_a[bram_pkg::CFG_RSTSYNC]),
    .rd_word(a_rd),
    .act_q(a_act),
    .we_q(a_we),
    .be_q(a_be),
    .addr_q(a_addr),
    .wdata_q(a_wdata),
    .dout(a_dout)
  );

  bram_port u_port_b (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .ce(b_ce),
    .we(b_we_in),
    .be(PORT_B_BE),
    .addr(PORT_B_ADDR),
    .wdata(PORT_B_WDATA),
    .out_rst(PORT_B_OUTPUT_RESET), // see RQ16
    .glob_clr(glob_clr),
    .width(st_ff.cfg_b[bram_pkg::CFG_WIDTH_LSB +: 3]),
    .wmode(st_ff.cfg_b[bram_pkg::CFG_WMODE_LSB +: 2]),
    .outreg(st_ff.cfg_b[bram_pkg::CFG_OUTREG]),
    .rst_sync(st_ff.cfg_b[bram_pkg::CFG_RSTSYNC]),
    .rd_word(b_rd),
    .act_q(b_act),
    .we_q(b_we),
    .be_q(b_be),
    .addr_q(b_addr),
    .wdata_q(b_wdata),
    .dout(b_dout)
  );

  // Array writes; port B is applied last and wins a same-word collision.
  always_comb begin
    nxt_mem = mem_ff;
    if (init_we) begin // see RQ8
      nxt_mem[int'(st_ff.init_addr) * bram_pkg::ENTRY_BITS +: bram_pkg::ENTRY_BITS] =
        HWDATA[bram_pkg::ENTRY_BITS-1:0];
    end
    if (a_act && a_we) begin // see RQ1
      nxt_mem = wr_word(nxt_mem, a_addr, st_ff.cfg_a[bram_pkg::CFG_WIDTH_LSB +: 3], a_be, a_wdata);
    end
    if (b_act && b_we) begin // see RQ1
      nxt_mem = wr_word(nxt_mem, b_addr, st_ff.cfg_b[bram_pkg::CFG_WIDTH_LSB +: 3], b_be, b_wdata);
    end
  end

  // Bus slave: writes land at the end of the data phase, reads see the result.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.gsync1 = GLOBAL_RESET_N;
    nxt_st.gsync2 = st_ff.gsync1;
    nxt_st.hready = 1'b1;
    nxt_st.hresp = 1'b0;
    if (st_ff.wpend) begin
      case (st_ff.waddr)
        bram_pkg::OFS_CTRL: begin
          nxt_st.run = HWDATA[bram_pkg::CTRL_RUN];
          nxt_st.mode = HWDATA[bram_pkg::CTRL_MODE_LSB +: 2];
        end
        bram_pkg::OFS_CFG_A: nxt_st.cfg_a = HWDATA[bram_pkg::CFG_BITS-1:0];
        bram_pkg::OFS_CFG_B: nxt_st.cfg_b = HWDATA[bram_pkg::CFG_BITS-1:0];
        bram_pkg::OFS_INIT_ADDR: nxt_st.init_addr = HWDATA[bram_pkg::ENTRY_AW-1:0];
        bram_pkg::OFS_INIT_DATA: begin
          if (!st_ff.run) nxt_st.init_addr = st_ff.init_addr + 11'h001; // see RQ8
        end
        default: nxt_st.init_addr = st_ff.init_addr;
      endcase
    end
    nxt_st.wpend = bus_sel && HWRITE && HADDR[31:8] == 24'h00_0000;
    nxt_st.waddr = {HADDR[7:2], 2'h0};
    nxt_st.hrdata = 32'h0000_0000;
    if (bus_sel && !HWRITE && HADDR[31:8] == 24'h00_0000) begin
      case ({HADDR[7:2], 2'h0})
        bram_pkg::OFS_CTRL: begin
          nxt_st.hrdata[bram_pkg::CTRL_RUN] = nxt_st.run;
          nxt_st.hrdata[bram_pkg::CTRL_MODE_LSB +: 2] = nxt_st.mode;
        end
        bram_pkg::OFS_CFG_A: nxt_st.hrdata[bram_pkg::CFG_BITS-1:0] = nxt_st.cfg_a;
        bram_pkg::OFS_CFG_B: nxt_st.hrdata[bram_pkg::CFG_BITS-1:0] = nxt_st.cfg_b;
        bram_pkg::OFS_STATUS: begin
          nxt_st.hrdata[bram_pkg::STAT_ERR] = cfg_bad(nxt_st.mode, nxt_st.cfg_a, nxt_st.cfg_b);
          nxt_st.hrdata[bram_pkg::STAT_ACTIVE] =
            nxt_st.run && !cfg_bad(nxt_st.mode, nxt_st.cfg_a, nxt_st.cfg_b);
        end
        bram_pkg::OFS_INIT_ADDR: nxt_st.hrdata[bram_pkg::ENTRY_AW-1:0] = nxt_st.init_addr;
        bram_pkg::OFS_INIT_DATA: begin
          nxt_st.hrdata[bram_pkg::ENTRY_BITS-1:0] =
            nxt_mem[int'(nxt_st.init_addr) * bram_pkg::ENTRY_BITS +: bram_pkg::ENTRY_BITS];
        end
        default: nxt_st.hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_ff <= '0;
      st_ff.mode <= bram_pkg::MODE_RST;
      st_ff.cfg_a <= bram_pkg::CFG_RST;
      st_ff.cfg_b <= bram_pkg::CFG_RST;
      st_ff.hready <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    mem_ff <= nxt_mem; // see RQ18
  end

  assign HREADYOUT = st_ff.hready;
  assign HRESP = st_ff.hresp;
  assign HRDATA = st_ff.hrdata;
  assign PORT_A_RDATA = a_dout;
  assign PORT_B_RDATA = b_dout;

endmodule : embedded_block_ram
`default_nettype wire

// ==== bench/bram_checker_asserts.sv ====
// Concurrent checks on the block RAM outputs, bound to the top module.
`timescale 1ns/1ns
`default_nettype none
module bram_checker (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic [31:0] HRDATA,
  input wire logic GLOBAL_RESET_N,
  input wire logic PORT_A_CE,
  input wire logic PORT_A_OUTPUT_RESET,
  input wire logic [bram_pkg::DATA_W-1:0] PORT_A_RDATA,
  input wire logic PORT_B_CE,
  input wire logic PORT_B_OUTPUT_RESET,
  input wire logic [bram_pkg::DATA_W-1:0] PORT_B_RDATA
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (SYS_RST);
  // Three edges with no capture, no reset and no bus traffic leave nothing to land.
  sequence s_quiet_a;
    (!PORT_A_CE && !PORT_A_OUTPUT_RESET && GLOBAL_RESET_N && !HTRANS[1]) [*3];
  endsequence
  sequence s_quiet_b;
    (!PORT_B_CE && !PORT_B_OUTPUT_RESET && GLOBAL_RESET_N && !HTRANS[1]) [*3];
  endsequence
  property p_rst_clear;
    $fell(SYS_RST) |-> (PORT_A_RDATA == '0 && PORT_B_RDATA == '0) [*2];
  endproperty
  property p_glob;
    !GLOBAL_RESET_N [*3] |=> PORT_A_RDATA == '0 && PORT_B_RDATA == '0;
  endproperty
  property p_loc_a;
    PORT_A_OUTPUT_RESET && PORT_A_CE |=> PORT_A_RDATA == '0;
  endproperty
  property p_loc_b;
    PORT_B_OUTPUT_RESET && PORT_B_CE |=> PORT_B_RDATA == '0;
  endproperty
  property p_hold_a;
    s_quiet_a |=> $stable(PORT_A_RDATA);
  endproperty
  property p_hold_b;
    s_quiet_b |=> $stable(PORT_B_RDATA);
  endproperty
  property p_ready;
    HREADYOUT && !HRESP;
  endproperty
  property p_rdata_idle;
    !(HSEL && HTRANS[1] && !HWRITE && HREADY) |=> HRDATA == '0;
  endproperty
  a_rst_clear: assert property (p_rst_clear)
    else $error("port data not clear after reset");
  a_glob: assert property (p_glob)
    else $error("global reset did not clear ports");
  a_loc_a: assert property (p_loc_a)
    else $error("port a local reset did not clear");
  a_loc_b: assert property (p_loc_b)
    else $error("port b local reset did not clear");
  a_hold_a: assert property (p_hold_a)
    else $error("port a data moved while idle");
  a_hold_b: assert property (p_hold_b)
    else $error("port b data moved while idle");
  a_ready: assert property (p_ready)
    else $error("bus wait or error response");
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("bus read data outside data phase");
endmodule : bram_checker
bind embedded_block_ram bram_checker chk_u (
  .SYS_CLK, .SYS_RST, .HSEL, .HTRANS, .HWRITE, .HREADY, .HREADYOUT, .HRESP, .HRDATA,
  .GLOBAL_RESET_N, .PORT_A_CE, .PORT_A_OUTPUT_RESET, .PORT_A_RDATA,
  .PORT_B_CE, .PORT_B_OUTPUT_RESET, .PORT_B_RDATA
);
`default_nettype wire

// ==== bench/fabric_port.sv ====
// Fabric-side model that drives one memory port.
`timescale 1ns/1ns
`default_nettype none
module fabric_port (
  input wire logic clk,
  output logic ce,
  output logic we,
  output logic [bram_pkg::BE_W-1:0] be,
  output logic [bram_pkg::ADDR_W-1:0] addr,
  output logic [bram_pkg::DATA_W-1:0] wdata
);
  initial begin
    ce = 1'b0;
    we = 1'b0;
    be = '0;
    addr = '0;
    wdata = '0;
  end
  // Presents one access for one edge; ce and we then drop and the other lines carry the inverse so stale values never match.
  task automatic access(input logic en, input logic wr, input logic [3:0] m,
      input logic [13:0] a, input logic [35:0] d);
    @(posedge clk);
    ce <= en;
    we <= wr;
    be <= m;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    ce <= 1'b0;
    we <= 1'b0;
    be <= ~m;
    addr <= ~a;
    wdata <= ~d;
    @(posedge clk);
  endtask : access
endmodule : fabric_port
`default_nettype wire

// ==== bench/embedded_block_ram_bench.sv ====
// Self-checking bench for the embedded block RAM.
`timescale 1ns/1ns
`default_nettype none
module embedded_block_ram_bench;
  typedef struct packed {
    logic [2:0] width;
    logic [1:0] wmode;
    logic wr;
    logic [3:0] be;
    logic [13:0] addr;
    logic [35:0] wdata;
    logic [35:0] want;
  } row_type;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic hreadyout, hresp;
  logic [31:0] hrdata, rd;
  logic glob_n = 1'b1;
  logic a_rst = 1'b0;
  logic b_rst = 1'b0;
  logic a_ce, a_we, b_ce, b_we;
  logic [3:0] a_be, b_be;
  logic [13:0] a_addr, b_addr;
  logic [35:0] a_wd, b_wd, a_rd, b_rd;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  logic [8:0] init_v [4] = '{9'h011, 9'h1A5, 9'h0F0, 9'h1FF};
  // Entries 4 to 7 are preloaded; the rows walk every width and write behaviour.
  row_type rows [11] = '{
    '{3'h5, 2'h0, 1'b0, 4'h0, 14'h0001, 36'h0, 36'hF_FBC3_4A11},
    '{3'h4, 2'h0, 1'b0, 4'h0, 14'h0002, 36'h0, 36'h0_0003_4A11},
    '{3'h3, 2'h0, 1'b0, 4'h0, 14'h0005, 36'h0, 36'h0_0000_01A5},
    '{3'h2, 2'h0, 1'b0, 4'h0, 14'h000B, 36'h0, 36'h0_0000_000A},
    '{3'h1, 2'h0, 1'b0, 4'h0, 14'h0014, 36'h0, 36'h0_0000_0001},
    '{3'h0, 2'h0, 1'b0, 4'h0, 14'h0028, 36'h0, 36'h0_0000_0001},
    '{3'h4, 2'h0, 1'b1, 4'h1, 14'h0002, 36'h0_0003_FFFF, 36'h0_0000_0001},
    '{3'h4, 2'h0, 1'b0, 4'h0, 14'h0002, 36'h0, 36'h0_0003_4BFF},
    '{3'h3, 2'h1, 1'b1, 4'h0, 14'h0006, 36'h0_0000_00AA, 36'h0_0000_00AA},
    '{3'h3, 2'h2, 1'b1, 4'h0, 14'h0006, 36'h0_0000_0155, 36'h0_0000_00AA},
    '{3'h3, 2'h0, 1'b0, 4'h0, 14'h0006, 36'h0, 36'h0_0000_0155}
  };
  embedded_block_ram dut_u (
    .SYS_CLK(sys_clk), .SYS_RST(sys_rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
    .HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata), .GLOBAL_RESET_N(glob_n),
    .PORT_A_CE(a_ce), .PORT_A_WE(a_we), .PORT_A_BE(a_be), .PORT_A_ADDR(a_addr),
    .PORT_A_WDATA(a_wd), .PORT_A_OUTPUT_RESET(a_rst), .PORT_A_RDATA(a_rd),
    .PORT_B_CE(b_ce), .PORT_B_WE(b_we), .PORT_B_BE(b_be), .PORT_B_ADDR(b_addr),
    .PORT_B_WDATA(b_wd), .PORT_B_OUTPUT_RESET(b_rst), .PORT_B_RDATA(b_rd)
  );
  fabric_port fab_a (.clk(sys_clk), .ce(a_ce), .we(a_we), .be(a_be), .addr(a_addr),
    .wdata(a_wd));
  fabric_port fab_b (.clk(sys_clk), .ce(b_ce), .we(b_we), .be(b_be), .addr(b_addr),
    .wdata(b_wd));
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [35:0] seen, input logic [35:0] want);
    compares++;
    if (seen !== want) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic report_and_stop;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop
  // Single AHB-Lite word transfer; read data is taken at the edge that ends the data phase.
  task automatic ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, ofs};
    hwrite <= wr;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1;
    check(a_rd, '0);
    check(b_rd, '0);
    ahb(1'b0, 8'h40, '0);
    check({4'h0, rd}, '0);
    ahb(1'b1, bram_pkg::OFS_INIT_ADDR, 32'h0000_0004);
    foreach (init_v[i])
      ahb(1'b1, bram_pkg::OFS_INIT_DATA, {23'h00_0000, init_v[i]});
    ahb(1'b1, bram_pkg::OFS_CTRL, 32'h0000_0001);
    foreach (rows[i]) begin
      ahb(1'b1, bram_pkg::OFS_CFG_A, {27'h000_0000, rows[i].wmode, rows[i].width});
      fab_a.access(1'b1, rows[i].wr, rows[i].be, rows[i].addr, rows[i].wdata);
      #1;
      check(a_rd, rows[i].want);
    end
    fab_a.access(1'b0, 1'b1, 4'hF, 14'h0006, 36'h0);
    #1;
    check(a_rd, 36'h0_0000_0155);
    fab_a.access(1'b1, 1'b0, 4'h0, 14'h0006, 36'h0);
    #1;
    check(a_rd, 36'h0_0000_0155);
    ahb(1'b1, bram_pkg::OFS_CFG_A, 32'h0000_0023);
    fab_a.access(1'b1, 1'b0, 4'h0, 14'h0005, 36'h0);
    #1;
    check(a_rd, 36'h0_0000_0155);
    fab_a.access(1'b1, 1'b0, 4'h0, 14'h0005, 36'h0);
    #1;
    check(a_rd, 36'h0_0000_01A5);
    ahb(1'b1, bram_pkg::OFS_CTRL, 32'h0000_0003);
    ahb(1'b1, bram_pkg::OFS_CFG_A, 32'h0000_0004);
    ahb(1'b1, bram_pkg::OFS_CFG_B, 32'h0000_0043);
    ahb(1'b0, bram_pkg::OFS_STATUS, '0);
    check({4'h0, rd}, 36'h0_0000_0002);
    ahb(1'b1, bram_pkg::OFS_CFG_A, 32'h0000_0005);
    ahb(1'b0, bram_pkg::OFS_STATUS, '0);
    check({4'h0, rd}, 36'h0_0000_0001);
    ahb(1'b1, bram_pkg::OFS_CFG_A, 32'h0000_0004);
    fab_a.access(1'b1, 1'b0, 4'h0, 14'h0002, 36'h0);
    fab_b.access(1'b1, 1'b0, 4'h0, 14'h0005, 36'h0);
    #1;
    check(a_rd, 36'h0_0003_4BFF);
    check(b_rd, 36'h0_0000_01A5);
    @(posedge sys_clk);
    a_rst <= 1'b1;
    @(posedge sys_clk);
    a_rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    check(a_rd, '0);
    check(b_rd, 36'h0_0000_01A5);
    @(posedge sys_clk);
    b_rst <= 1'b1;
    @(posedge sys_clk);
    b_rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    check(b_rd, 36'h0_0000_01A5);
    @(posedge sys_clk);
    a_rst <= 1'b1;
    b_rst <= 1'b1;
    fork
      fab_a.access(1'b1, 1'b0, 4'h0, 14'h0002, 36'h0);
      fab_b.access(1'b1, 1'b0, 4'h0, 14'h0005, 36'h0);
    join
    a_rst <= 1'b0;
    b_rst <= 1'b0;
    fab_b.access(1'b1, 1'b0, 4'h0, 14'h0005, 36'h0);
    #1;
    check(a_rd, '0);
    check(b_rd, 36'h0_0000_01A5);
    @(posedge sys_clk);
    glob_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    glob_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    check(a_rd, '0);
    check(b_rd, '0);
    fab_b.access(1'b1, 1'b0, 4'h0, 14'h0005, 36'h0);
    #1;
    check(b_rd, 36'h0_0000_01A5);
    report_and_stop();
  end
endmodule : embedded_block_ram_bench
`default_nettype wire
